// file: hw/tiq_pkg.sv
// constants shared by the transmit i/q interpolator
package tiq_pkg;
    localparam int WORD_W      = 6;
    localparam int SAMP_W      = 12;
    localparam int PAIR_W      = 2 * SAMP_W;
    localparam int FIFO_DEPTH  = 32;
    localparam int FIFO_AW     = 5;
    localparam int WORDS_PER_SYMBOL = 4;
    localparam logic [1:0] IDX_I_HI = 2'h0;
    localparam logic [1:0] IDX_I_LO = 2'h1;
    localparam logic [1:0] IDX_Q_HI = 2'h2;
    localparam logic [1:0] IDX_Q_LO = 2'h3;
    // half-band stages: pairs of symmetric taps around the centre
    localparam int HB1_TAPS    = 15;
    localparam int HB2_TAPS    = 11;
    localparam int HB1_PAIRS   = (HB1_TAPS + 1) / 4;
    localparam int HB2_PAIRS   = (HB2_TAPS + 1) / 4;
    localparam int COEF_W      = 12;
    localparam int COEF_SHIFT  = 9;
    localparam logic signed [COEF_W-1:0] HB1_COEF [0:3] = '{12'h136, 12'hFB2, 12'h01D, 12'hFFB};
    localparam logic signed [COEF_W-1:0] HB2_COEF [0:3] = '{12'h12C, 12'hFC8, 12'h00C, 12'h000};
    // cic stage
    localparam int CIC_ORDER   = 3;
    localparam int CIC_W       = 20;
    localparam int RECIP_W     = 17;
    localparam int RECIP_SHIFT = 16;
    localparam logic [RECIP_W-1:0] RECIP_R3 = 17'h0_1C71;
    localparam logic [RECIP_W-1:0] RECIP_R4 = 17'h0_1000;
    localparam logic [2:0] RATIO_3 = 3'h3;
    localparam logic [2:0] RATIO_4 = 3'h4;
    // latency of the whole chain in converter clock cycles
    localparam int LATENCY_SYS = 119;
    localparam int CORE_LAT    = 45;
    localparam int ALIGN_PAD   = LATENCY_SYS - CORE_LAT;
endpackage

// file: hw/tiq_interp.sv
// transmit i/q data assembler, half-band interpolators and cic interpolator
//
// Behaviour
// - master clock driven out; one 6-bit word sampled per master clock rising edge.
// - frame marker high marks the first word of a symbol and realigns assembly.
// - symbol words arrive as i upper, i lower, q upper, q lower.
// - upper and lower halves join into one signed 12-bit two's-complement value.
// - one i/q pair per four words, a quarter of the master clock rate.
// - first half-band stage is a 15-tap filter doubling the rate.
// - second half-band stage is an 11-tap filter doubling it again.
// - both half-band stages use symmetric coefficients for linear phase.
// - cic is an interpolator: combs, zero stuffing, then integrators.
// - cic ratio takes only the value 3 or 4.
// - one ratio setting sets the cic ratio and divides the master clock.
// - cic has order three and differential delay one.
// - cic response is cube of length-r moving sum over r squared, unity dc gain.
// - at cic ratio 4, first effect of an input word reaches the output 119 converter cycles later; 109 at ratio 3.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// fifo
// ----------------------------------------------------------------------------
module tiq_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    wire              full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire              empty = (wr_ptr == rd_ptr);
    wire              push  = in_valid && !full;
    wire              pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + (AW+1)'(push);
            rd_ptr <= rd_ptr + (AW+1)'(pop);
        end
    end
endmodule

// ----------------------------------------------------------------------------
// half-band interpolate-by-two, polyphase
// ----------------------------------------------------------------------------
module tiq_halfband #(
    parameter int                                      NP   = 4,
    parameter logic signed [tiq_pkg::COEF_W-1:0]       COEF [0:3] = '{default: 12'h000}
) (
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    input  wire logic                                  in_stb,
    input  wire logic                                  out_stb,
    input  wire logic signed [tiq_pkg::SAMP_W-1:0]     x,
    output logic signed      [tiq_pkg::SAMP_W-1:0]     y
);
    localparam int ACC_W = tiq_pkg::SAMP_W + tiq_pkg::COEF_W + 3;
    logic signed [tiq_pkg::SAMP_W-1:0] line [2*NP];
    logic signed [ACC_W-1:0]           acc;
    logic signed [ACC_W-1:0]           scaled;
    logic signed [tiq_pkg::SAMP_W-1:0] odd_out;

    // symmetric pairs: one multiply per pair, linear phase by construction
    always_comb
    begin
        acc = '0;
        for (int k = 0; k < NP; k++)
        begin
            acc = acc + ACC_W'(COEF[k]) * (ACC_W'(line[NP-1-k]) + ACC_W'(line[NP+k]));
        end
    end

    assign scaled  = acc >>> tiq_pkg::COEF_SHIFT;
    // saturate: overshoot near full scale must not wrap sign
    assign odd_out = (scaled > ACC_W'(2047)) ? 12'h7FF :
                     (scaled < -ACC_W'(2048)) ? 12'h800 : scaled[tiq_pkg::SAMP_W-1:0];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            line  <= '{default: '0};
            y     <= '0;
        end
        else
        begin
            if (in_stb)
            begin
                line[0] <= x;
                for (int k = 1; k < 2*NP; k++)
                begin
                    line[k] <= line[k-1];
                end
            end
            if (out_stb)
            begin
                // centre tap on even phase, pair sum on odd: two outputs per input
                y     <= in_stb ? line[NP-1] : odd_out;
            end
        end
    end
endmodule

// ----------------------------------------------------------------------------
// cic interpolator, order three, differential delay one
// ----------------------------------------------------------------------------
module tiq_cic (
    input  wire logic                                  core_clk,
    input  wire logic                                  rst,
    input  wire logic                                  in_stb,
    input  wire logic                                  ratio_4,
    input  wire logic signed [tiq_pkg::SAMP_W-1:0]     x,
    output logic signed      [tiq_pkg::SAMP_W-1:0]     y
);
    localparam int W = tiq_pkg::CIC_W;
    localparam int PW = W + tiq_pkg::RECIP_W + 1;
    logic signed [W-1:0]  comb_dly [tiq_pkg::CIC_ORDER];
    logic signed [W-1:0]  comb_out [tiq_pkg::CIC_ORDER+1];
    logic signed [W-1:0]  integ    [tiq_pkg::CIC_ORDER];
    logic signed [W-1:0]  stuffed;
    logic signed [PW-1:0] prod;
    logic signed [PW-1:0] norm;

    assign comb_out[0] = W'(x);
    genvar g;
    generate
        for (g = 0; g < tiq_pkg::CIC_ORDER; g++)
        begin : g_comb
            assign comb_out[g+1] = comb_out[g] - comb_dly[g];
        end
    endgenerate

    // zero stuffing between the low-rate combs and high-rate integrators
    assign stuffed = in_stb ? comb_out[tiq_pkg::CIC_ORDER] : '0;

    // wrap-around integrators are exact as long as w covers the r^3 growth
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            comb_dly <= '{default: '0};
            integ    <= '{default: '0};
        end
        else
        begin
            if (in_stb)
            begin
                for (int k = 0; k < tiq_pkg::CIC_ORDER; k++)
                begin
                    comb_dly[k] <= comb_out[k];
                end
            end
            integ[0] <= integ[0] + stuffed;
            for (int k = 1; k < tiq_pkg::CIC_ORDER; k++)
            begin
                integ[k] <= integ[k] + integ[k-1];
            end
        end
    end

    // stuffing costs a factor r, so scale by 1/r^2; 1/9 rounded down so -2048 cannot wrap
    assign prod = PW'(integ[tiq_pkg::CIC_ORDER-1]) *
                  PW'({1'b0, ratio_4 ? tiq_pkg::RECIP_R4 : tiq_pkg::RECIP_R3});
    assign norm = prod >>> tiq_pkg::RECIP_SHIFT;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            y <= '0;
        end
        else
        begin
            y <= norm[tiq_pkg::SAMP_W-1:0];
        end
    end
endmodule

// ----------------------------------------------------------------------------
// top: master clock, assembler, fifo, filter chain
// ----------------------------------------------------------------------------
module tiq_interp (
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              cic_ratio_4,
    input  wire logic [tiq_pkg::WORD_W-1:0]        tx_word,
    input  wire logic                              tx_frame,
    output logic                                   mclk_out,
    output logic                                   fifo_overflow,
    output logic                                   out_valid,
    output logic signed [tiq_pkg::SAMP_W-1:0]      dac_i,
    output logic signed [tiq_pkg::SAMP_W-1:0]      dac_q
);
    logic [tiq_pkg::WORD_W-1:0]          word_s1;
    logic [tiq_pkg::WORD_W-1:0]          word_s2;
    logic                                frame_s1;
    logic                                frame_s2;
    logic                                ratio_s1;
    logic                                ratio_s2;
    logic                                ratio_4;
    logic [2:0]                          sub_cnt;
    logic [1:0]                          mclk_cnt;
    logic [1:0]                          word_idx;
    logic [tiq_pkg::WORD_W-1:0]          i_hi;
    logic [tiq_pkg::WORD_W-1:0]          i_lo;
    logic [tiq_pkg::WORD_W-1:0]          q_hi;
    logic                                pair_valid;
    logic [tiq_pkg::PAIR_W-1:0]          pair_data;
    logic                                fifo_in_ready;
    logic                                fifo_out_valid;
    logic [tiq_pkg::PAIR_W-1:0]          fifo_out_data;
    logic signed [tiq_pkg::SAMP_W-1:0]   hb1_x  [2];
    logic signed [tiq_pkg::SAMP_W-1:0]   hb1_y  [2];
    logic signed [tiq_pkg::SAMP_W-1:0]   hb2_y  [2];
    logic signed [tiq_pkg::SAMP_W-1:0]   cic_y  [2];
    logic [tiq_pkg::PAIR_W-1:0]          pad [tiq_pkg::ALIGN_PAD];
    logic                                run;

    wire [2:0] ratio     = ratio_4 ? tiq_pkg::RATIO_4 : tiq_pkg::RATIO_3;
    wire       sub_last  = (sub_cnt == ratio - 3'h1);
    wire       word_take = sub_last;
    wire [1:0] next_idx  = frame_s2 ? tiq_pkg::IDX_I_HI : word_idx;
    // hb1 takes a pair once per symbol period, hb2 one cycle behind, cic two cycles behind
    wire       hb1_in    = sub_last && (mclk_cnt == 2'h3);
    wire       hb1_out   = sub_last && mclk_cnt[0];
    wire       hb2_in    = (sub_cnt == 3'h0) && !mclk_cnt[0] && run;
    wire       hb2_out   = (sub_cnt == 3'h0) && run;
    wire       cic_in    = (sub_cnt == 3'h1) && run;

    // pins come from outside the clock domain
    always_ff @(posedge core_clk)
    begin
        word_s1  <= tx_word;
        word_s2  <= word_s1;
        frame_s1 <= tx_frame;
        frame_s2 <= frame_s1;
        ratio_s1 <= cic_ratio_4;
        ratio_s2 <= ratio_s1;
    end

    // master clock divides core clock by the cic ratio; ratio changes at a symbol boundary
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ratio_4  <= 1'b0;
            sub_cnt  <= 3'h0;
            mclk_cnt <= 2'h0;
            mclk_out <= 1'b0;
            run      <= 1'b0;
        end
        else
        begin
            sub_cnt  <= sub_last ? 3'h0 : sub_cnt + 3'h1;
            mclk_out <= sub_last || (sub_cnt == 3'h0 && ratio_4);
            if (sub_last)
            begin
                mclk_cnt <= mclk_cnt + 2'h1;
                run      <= 1'b1;
            end
            if (hb1_in)
            begin
                ratio_4 <= ratio_s2;
            end
        end
    end

    // assembler: four words in fixed order form one signed i/q pair
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            word_idx   <= tiq_pkg::IDX_I_HI;
            i_hi       <= '0;
            i_lo       <= '0;
            q_hi       <= '0;
            pair_valid <= 1'b0;
            pair_data  <= '0;
        end
        else
        begin
            pair_valid <= 1'b0;
            if (word_take)
            begin
                word_idx <= next_idx + 2'h1;
                unique case (next_idx)
                    tiq_pkg::IDX_I_HI: i_hi <= word_s2;
                    tiq_pkg::IDX_I_LO: i_lo <= word_s2;
                    tiq_pkg::IDX_Q_HI: q_hi <= word_s2;
                    tiq_pkg::IDX_Q_LO:
                    begin
                        pair_valid <= 1'b1;
                        pair_data  <= {i_hi, i_lo, q_hi, word_s2};
                    end
                endcase
            end
        end
    end

    // the source cannot be stalled, so a full fifo drops the pair and flags it
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            fifo_overflow <= 1'b0;
        end
        else if (pair_valid && !fifo_in_ready)
        begin
            fifo_overflow <= 1'b1;
        end
    end

    tiq_fifo #(
        .WIDTH (tiq_pkg::PAIR_W),
        .DEPTH (tiq_pkg::FIFO_DEPTH),
        .AW    (tiq_pkg::FIFO_AW)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (pair_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (pair_data),
        .out_valid (fifo_out_valid),
        .out_ready (hb1_in),
        .out_data  (fifo_out_data)
    );

    // an empty fifo feeds silence rather than stale data
    assign hb1_x[0] = fifo_out_valid ? fifo_out_data[tiq_pkg::PAIR_W-1:tiq_pkg::SAMP_W] : '0;
    assign hb1_x[1] = fifo_out_valid ? fifo_out_data[tiq_pkg::SAMP_W-1:0] : '0;

    genvar c;
    generate
        for (c = 0; c < 2; c++)
        begin : g_path
            tiq_halfband #(
                .NP   (tiq_pkg::HB1_PAIRS),
                .COEF (tiq_pkg::HB1_COEF)
            ) u_first_halfband_stage (
                .core_clk (core_clk),
                .rst      (rst),
                .in_stb   (hb1_in),
                .out_stb  (hb1_out),
                .x        (hb1_x[c]),
                .y        (hb1_y[c])
            );
            tiq_halfband #(
                .NP   (tiq_pkg::HB2_PAIRS),
                .COEF (tiq_pkg::HB2_COEF)
            ) u_second_halfband_stage (
                .core_clk (core_clk),
                .rst      (rst),
                .in_stb   (hb2_in),
                .out_stb  (hb2_out),
                .x        (hb1_y[c]),
                .y        (hb2_y[c])
            );
            tiq_cic u_cic (
                .core_clk (core_clk),
                .rst      (rst),
                .in_stb   (cic_in),
                .ratio_4  (ratio_4),
                .x        (hb2_y[c]),
                .y        (cic_y[c])
            );
        end
    endgenerate

    // alignment delay brings the chain to its 119-cycle end-to-end latency at cic ratio 4
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pad       <= '{default: '0};
            dac_i     <= '0;
            dac_q     <= '0;
            out_valid <= 1'b0;
        end
        else
        begin
            pad[0] <= {cic_y[0], cic_y[1]};
            for (int k = 1; k < tiq_pkg::ALIGN_PAD; k++)
            begin
                pad[k] <= pad[k-1];
            end
            dac_i     <= pad[tiq_pkg::ALIGN_PAD-1][tiq_pkg::PAIR_W-1:tiq_pkg::SAMP_W];
            dac_q     <= pad[tiq_pkg::ALIGN_PAD-1][tiq_pkg::SAMP_W-1:0];
            out_valid <= run;
        end
    end
endmodule

`default_nettype wire

// file: dv/tiq_chk.sv
// assertion checker for the transmit i/q interpolator top ports
`timescale 1ns/1ps
`default_nettype none

module tiq_chk (
    input wire logic                                 core_clk,
    input wire logic                                 rst,
    input wire logic                                 cic_ratio_4,
    input wire logic        [tiq_pkg::WORD_W-1:0]    tx_word,
    input wire logic                                 tx_frame,
    input wire logic                                 mclk_out,
    input wire logic                                 fifo_overflow,
    input wire logic                                 out_valid,
    input wire logic signed [tiq_pkg::SAMP_W-1:0]    dac_i,
    input wire logic signed [tiq_pkg::SAMP_W-1:0]    dac_q
);
    // ------------------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------------------
    // settle span covers the 119-cycle latency plus the dc settling tail
    localparam int SETTLE = 400;
    // ratio is only latched at a symbol boundary, so skip the first periods
    localparam int WARM   = 64;
    logic [9:0]                  run_cnt;
    logic [9:0]                  same_cnt;
    logic [tiq_pkg::WORD_W-1:0]  last_word;
    wire logic                   warm = (run_cnt >= 10'(WARM));
    wire logic                   flushed = (same_cnt == 10'(SETTLE));

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            run_cnt   <= 10'h000;
            same_cnt  <= 10'h000;
            last_word <= 6'h00;
        end
        else
        begin
            run_cnt   <= warm ? run_cnt : run_cnt + 10'h001;
            same_cnt  <= (tx_word != last_word) ? 10'h000 : (flushed ? same_cnt : same_cnt + 10'h001);
            last_word <= tx_word;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_RESET_QUIET: assert property ($fell(rst) |-> !mclk_out && !out_valid && !fifo_overflow
        && dac_i == 12'h000 && dac_q == 12'h000) else $error("outputs not quiet after reset");
    AST_VALID_RISE: assert property ($fell(rst) |-> ##[1:24] out_valid)
        else $error("output valid late after reset");
    AST_VALID_HOLD: assert property (out_valid |=> out_valid)
        else $error("output valid dropped");
    AST_NO_OVERFLOW: assert property (!fifo_overflow)
        else $error("pair rate exceeds filter rate");
    AST_MCLK_R4: assert property (warm && $rose(mclk_out) && cic_ratio_4
        |=> mclk_out ##1 !mclk_out [*2] ##1 mclk_out) else $error("master clock shape wrong for ratio 4");
    AST_MCLK_R3: assert property (warm && $rose(mclk_out) && !cic_ratio_4
        |=> !mclk_out [*2] ##1 mclk_out) else $error("master clock shape wrong for ratio 3");
    AST_IDLE_ZERO: assert property (flushed && tx_word == 6'h00 |-> dac_i == 12'h000 && dac_q == 12'h000)
        else $error("zero input gives nonzero output");
    AST_IQ_MATCH: assert property (flushed |-> dac_i == dac_q)
        else $error("equal i and q inputs give unequal outputs");

    COV_R4_CLOCK: cover property (warm && $rose(mclk_out) && cic_ratio_4);
    COV_R3_CLOCK: cover property (warm && $rose(mclk_out) && !cic_ratio_4);
    COV_FLUSHED: cover property (flushed && tx_word != 6'h00);
endmodule

bind tiq_interp tiq_chk chk (
    .core_clk      (core_clk),
    .rst           (rst),
    .cic_ratio_4   (cic_ratio_4),
    .tx_word       (tx_word),
    .tx_frame      (tx_frame),
    .mclk_out      (mclk_out),
    .fifo_overflow (fifo_overflow),
    .out_valid     (out_valid),
    .dac_i         (dac_i),
    .dac_q         (dac_q)
);

`default_nettype wire

// file: dv/tiq_src.sv
// baseband source model delivering multiplexed i/q words on the master clock
`timescale 1ns/1ps
`default_nettype none

module tiq_src (
    input  wire logic                              core_clk,
    input  wire logic                              rst,
    input  wire logic                              mclk_out,
    input  wire logic        [1:0]                 first_idx,
    input  wire logic signed [tiq_pkg::SAMP_W-1:0] samp_i,
    input  wire logic signed [tiq_pkg::SAMP_W-1:0] samp_q,
    output logic             [tiq_pkg::WORD_W-1:0] tx_word,
    output logic                                   tx_frame
);
    // ------------------------------------------------------------------------
    // word sequencer
    // ------------------------------------------------------------------------
    logic                         mclk_seen;
    logic [1:0]                   idx;
    logic [tiq_pkg::WORD_W-1:0]   next_word;
    // one new word per master clock rise, never skipped, source cannot stall
    wire logic                    new_word = mclk_out && !mclk_seen;

    // i upper, i lower, q upper, q lower
    assign next_word = (idx == tiq_pkg::IDX_I_HI) ? samp_i[11:6] :
                       (idx == tiq_pkg::IDX_I_LO) ? samp_i[5:0]  :
                       (idx == tiq_pkg::IDX_Q_HI) ? samp_q[11:6] : samp_q[5:0];

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mclk_seen <= 1'b0;
            idx       <= first_idx;
            tx_word   <= 6'h00;
            tx_frame  <= 1'b0;
        end
        else
        begin
            mclk_seen <= mclk_out;
            if (new_word)
            begin
                tx_word  <= next_word;
                tx_frame <= (idx == tiq_pkg::IDX_I_HI);
                idx      <= idx + 2'h1;
            end
        end
    end
endmodule

`default_nettype wire

// file: dv/tx_iq_interpolator_tb_top.sv
// self-checking testbench for the transmit i/q interpolator
`timescale 1ns/1ps
`default_nettype none

module tx_iq_interpolator_tb_top;
    // ------------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------------
    logic                                 core_clk    = 1'b0;
    logic                                 rst         = 1'b1;
    logic                                 cic_ratio_4 = 1'b0;
    logic        [1:0]                    first_idx   = 2'h0;
    logic signed [tiq_pkg::SAMP_W-1:0]    samp_i      = 12'h000;
    logic signed [tiq_pkg::SAMP_W-1:0]    samp_q      = 12'h000;
    logic        [tiq_pkg::WORD_W-1:0]    tx_word;
    logic                                 tx_frame;
    logic                                 mclk_out;
    logic                                 fifo_overflow;
    logic                                 out_valid;
    logic signed [tiq_pkg::SAMP_W-1:0]    dac_i;
    logic signed [tiq_pkg::SAMP_W-1:0]    dac_q;
    int                                   n_errors    = 0;
    int                                   n_compared  = 0;

    always #5 core_clk = ~core_clk;

    tiq_interp dut (.core_clk(core_clk), .rst(rst), .cic_ratio_4(cic_ratio_4), .tx_word(tx_word),
        .tx_frame(tx_frame), .mclk_out(mclk_out), .fifo_overflow(fifo_overflow), .out_valid(out_valid),
        .dac_i(dac_i), .dac_q(dac_q));
    tiq_src src (.core_clk(core_clk), .rst(rst), .mclk_out(mclk_out), .first_idx(first_idx),
        .samp_i(samp_i), .samp_q(samp_q), .tx_word(tx_word), .tx_frame(tx_frame));

    // ------------------------------------------------------------------------
    // compare and control tasks
    // ------------------------------------------------------------------------
    task automatic check_near(input logic signed [31:0] got, input logic signed [31:0] exp, input int tol);
        logic signed [31:0] diff;
        diff = got - exp;
        n_compared++;
        if ((^got === 1'bx) || diff > tol || -diff > tol)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // reset is the only safe point to change the ratio
    task automatic do_reset(input logic r4, input logic [1:0] idx, input logic [11:0] si, input logic [11:0] sq);
        @(posedge core_clk);
        rst         <= 1'b1;
        cic_ratio_4 <= r4;
        first_idx   <= idx;
        samp_i      <= si;
        samp_q      <= sq;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    // dc levels only: bandwidth stays far inside the flat passband
    task automatic test_dc(input logic r4, input logic [1:0] idx, input logic [11:0] si, input logic [11:0] sq);
        int  rises;
        logic prev;
        rises = 0;
        prev  = 1'b0;
        do_reset(r4, idx, si, sq);
        repeat (600) @(negedge core_clk);
        check_near(dac_i, $signed(si), 8);
        check_near(dac_q, $signed(sq), 8);
        repeat (120)
        begin
            @(negedge core_clk);
            if (mclk_out && !prev)
                rises++;
            prev = mclk_out;
        end
        check_near(rises, r4 ? 30 : 40, 1);
        check_flag(fifo_overflow, 1'b0);
        check_flag(out_valid, 1'b1);
        $display("test dc ratio4=%0d start=%0d done", r4, idx);
    endtask

    task automatic test_latency();
        int t0;
        int n;
        t0 = -1;
        do_reset(1'b1, 2'h0, 12'h000, 12'h000);
        repeat (500) @(posedge core_clk);
        samp_i <= 12'h400;
        for (n = 0; n < 400; n++)
        begin
            @(negedge core_clk);
            if (t0 < 0 && tx_word != 6'h00)
                t0 = n;
            if (t0 >= 0 && dac_i !== 12'h000)
                break;
        end
        check_near(n - t0, tiq_pkg::LATENCY_SYS, 4);
        repeat (600) @(negedge core_clk);
        check_near(dac_i, 1024, 8);
        check_near(dac_q, 0, 0);
        $display("test latency done");
    endtask

    // full-scale pairs cross the fifo with both halves intact and nothing dropped
    task automatic test_fifo();
        do_reset(1'b0, 2'h1, 12'h7FF, 12'h800);
        repeat (600) @(negedge core_clk);
        check_near(dac_i, 2047, 8);
        check_near(dac_q, -2048, 8);
        check_flag(fifo_overflow, 1'b0);
        $display("test fifo done");
    endtask

    // ------------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------------
    initial
    begin
        test_dc(1'b0, 2'h0, 12'h2C1, 12'hB4E);
        test_dc(1'b1, 2'h0, 12'hB4E, 12'h2C1);
        test_dc(1'b0, 2'h2, 12'h7A3, 12'h15C);
        test_dc(1'b1, 2'h2, 12'h7F0, 12'h801);
        test_dc(1'b1, 2'h0, 12'h208, 12'h208);
        test_latency();
        test_fifo();
        report_and_stop();
    end

    initial
    begin
        #150000;
        n_errors++;
        report_and_stop();
    end
endmodule

`default_nettype wire
